// ---- design/sfpc_pkg.sv ----
`default_nettype none
package sfpc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPC,
        ST_BODY,
        ST_DROP,
        ST_BUSY
    } sfpc_state_t;

    typedef struct packed {
        logic       first;
        logic [7:0] data;
    } sfpc_rx_t;
endpackage
`default_nettype wire

// ---- design/sfpc_regs.svh ----
`ifndef SFPC_REGS_SVH
`define SFPC_REGS_SVH
// system clock rate
`define SFPC_CLK_MHZ      10
// self-timed program or erase cycle length
`define SFPC_PROG_TIME_US 3000
`define SFPC_PROG_CYC     (`SFPC_PROG_TIME_US * `SFPC_CLK_MHZ)
`define SFPC_PAGE_STD     9'h108
`define SFPC_PAGE_BIN     9'h100
`define SFPC_FIFO_DEPTH   4
`define SFPC_BIT_LAST     3'h7
// pins idle high: cs_n, sck, si, wp_n, reset_n
`define SFPC_PIN_IDLE     5'h1f
`endif

// ---- design/sfpc_top.sv ----
// How it works
// R1: chip select high: standby, output released
// R2: deselected: serial input fully ignored
// R3: frames open on cs fall, close on rise
// R4: running timed cycle defers standby until done
// R5: input bits captured on rising clock edge
// R6: output bit changes on falling clock edge
// R7: works with clock idling low or high
// R8: wp low protects flagged sectors
// R9: wp low freezes protection register contents
// R10: program/erase under wp low discarded till deselect
// R11: enable-protect and lockdown still accepted
// R12: wp reads unasserted when left floating; here only until first sampled after rst, no pull-up
// R13: reset pin low aborts, forces idle
// R14: held in reset while pin low
// R15: internal power-on reset, pin free
// R16: program and erase timed internally
// R17: page size 264, or 256 if strapped
// R18: opcode byte first, then address bytes
// R19: all bytes move most significant first
// R20: output driven only while selected and reading
`include "sfpc_regs.svh"
`default_nettype none

// ====================================================================
// pin synchroniser
module sfpc_sync #(
    parameter int          W    = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= IDLE;
            q      <= IDLE;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ====================================================================
// receive fifo
module sfpc_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;
    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ====================================================================
// serial front end
module sfpc_top #(
    parameter int unsigned PROG_CYC = `SFPC_PROG_CYC,
    parameter bit          BIN_PAGE = 1'b0,
    // command encodings, arbitrary defaults
    parameter logic [31:0] PE_OPS   = 32'h04030201,
    parameter logic [15:0] SPR_OPS  = 16'h0605,
    parameter logic [7:0]  ENSP_OP  = 8'h07,
    parameter logic [7:0]  LOCK_OP  = 8'h08
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             cs_n_pin,
    input  wire logic             sck_pin,
    input  wire logic             si_pin,
    input  wire logic             wp_n_pin,
    input  wire logic             reset_n_pin,
    output logic                  so_out,
    output logic                  so_oe,
    output logic                  rx_valid,
    input  wire logic             rx_ready,
    output sfpc_pkg::sfpc_rx_t    rx_word,
    input  wire logic [7:0]       tx_byte,
    input  wire logic             rd_active,
    input  wire logic             sect_flag,
    output logic                  sect_prot,
    output logic                  spr_lock,
    output logic                  busy,
    output logic                  standby,
    output logic [8:0]            page_size,
    output logic                  overrun
);
    localparam int CW = $clog2(PROG_CYC + 1);

    // ================================================================
    // pins
    logic [4:0] pin_s;
    logic [4:0] pin_d_q;
    // R12: no pad pull-up; sync resets high, so a float reads unasserted only until first sampled
    sfpc_sync #(.W(5), .IDLE(`SFPC_PIN_IDLE)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       ({cs_n_pin, sck_pin, si_pin, wp_n_pin, reset_n_pin}),
        .q       (pin_s)
    );
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_d_q <= `SFPC_PIN_IDLE;
        end else begin
            pin_d_q <= pin_s;
        end
    end
    wire cs_n_s   = pin_s[4];
    wire si_s     = pin_s[2];
    wire wp_low   = !pin_s[1];
    // R13: reset pin low acts as a synchronous abort
    wire soft_rst = !pin_s[0];
    // R3: frame boundaries from chip select edges
    wire cs_fall  = pin_d_q[4] && !pin_s[4];
    wire cs_rise  = !pin_d_q[4] && pin_s[4];
    // R7: edges only, idle level of sck never matters
    wire sck_rise = !pin_d_q[3] && pin_s[3];
    wire sck_fall = pin_d_q[3] && !pin_s[3];

    // ================================================================
    // opcode decode
    function automatic logic in_list4(input logic [7:0] op, input logic [31:0] l);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            hit = hit | (op == l[8*i +: 8]);
        end
        return hit;
    endfunction

    sfpc_pkg::sfpc_state_t st_q;
    sfpc_pkg::sfpc_state_t st_d;
    logic [2:0]          bit_q;
    logic [6:0]          sh_q;
    logic                pe_q;
    logic [CW-1:0]       cnt_q;
    logic                pend_v_q;
    sfpc_pkg::sfpc_rx_t  pend_q;
    logic [6:0]          tx_q;
    logic                fifo_rdy;

    wire       shifting  = (st_q == sfpc_pkg::ST_OPC) || (st_q == sfpc_pkg::ST_BODY);
    // R5: capture on rising sck only while shifting
    wire       take_bit  = shifting && sck_rise && !cs_n_s;
    wire       byte_done = take_bit && (bit_q == `SFPC_BIT_LAST);
    // R19: msb arrives first, lands at the top
    wire [7:0] rx_byte   = {sh_q, si_s};
    wire       is_pe     = in_list4(rx_byte, PE_OPS);
    wire       is_spr    = (rx_byte == SPR_OPS[7:0]) || (rx_byte == SPR_OPS[15:8]);
    wire       is_exempt = (rx_byte == ENSP_OP) || (rx_byte == LOCK_OP);
    // R9: protection register writes also refused under wp low
    // R11: enable-protect and lockdown pass regardless
    wire       drop_op   = wp_low && (is_pe || is_spr) && !is_exempt;
    wire       opc_done  = byte_done && (st_q == sfpc_pkg::ST_OPC);
    wire       push_byte = byte_done && !(opc_done && drop_op);
    wire       push_ok   = pend_v_q && fifo_rdy;

    // ================================================================
    // control state machine
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            sfpc_pkg::ST_IDLE: begin
                // R2: nothing is taken until a fresh cs fall
                if (cs_fall) begin
                    st_d = sfpc_pkg::ST_OPC;
                end
            end
            sfpc_pkg::ST_OPC: begin
                if (cs_rise) begin
                    st_d = sfpc_pkg::ST_IDLE;
                end else if (opc_done) begin
                    // R10: discarded command waits out the frame
                    st_d = drop_op ? sfpc_pkg::ST_DROP : sfpc_pkg::ST_BODY;
                end
            end
            sfpc_pkg::ST_BODY: begin
                // R16: accepted program/erase starts its own timer
                if (cs_rise) begin
                    st_d = pe_q ? sfpc_pkg::ST_BUSY : sfpc_pkg::ST_IDLE;
                end
            end
            sfpc_pkg::ST_DROP: begin
                if (cs_rise) begin
                    st_d = sfpc_pkg::ST_IDLE;
                end
            end
            sfpc_pkg::ST_BUSY: begin
                // R4: standby only when the timed cycle has ended
                if (cnt_q == '0) begin
                    st_d = sfpc_pkg::ST_IDLE;
                end
            end
        endcase
        // R14: held idle for as long as the pin stays low
        if (soft_rst) begin
            st_d = sfpc_pkg::ST_IDLE;
        end
    end

    // R15: rst is the internal power-on reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= sfpc_pkg::ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (st_q != sfpc_pkg::ST_BUSY) begin
            cnt_q <= CW'(PROG_CYC - 1);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // ================================================================
    // receive shifter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_q <= '0;
            sh_q  <= '0;
            pe_q  <= 1'b0;
        end else begin
            if (cs_fall || soft_rst) begin
                bit_q <= '0;
            end else if (take_bit) begin
                bit_q <= bit_q + 1'b1;
                sh_q  <= rx_byte[6:0];
            end
            if (cs_fall || soft_rst) begin
                pe_q <= 1'b0;
            end else if (opc_done) begin
                pe_q <= is_pe;
            end
        end
    end

    // one-byte holding stage; a new byte set wins over its drain
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend_v_q <= 1'b0;
            pend_q   <= '0;
            overrun  <= 1'b0;
        end else begin
            if (push_byte) begin
                pend_v_q <= 1'b1;
                // R18: first byte of a frame is the opcode
                pend_q   <= '{first: (st_q == sfpc_pkg::ST_OPC), data: rx_byte};
            end else if (push_ok || soft_rst) begin
                pend_v_q <= 1'b0;
            end
            // sck cannot be stalled, so a late drain is only reported
            if (push_byte && pend_v_q && !fifo_rdy) begin
                overrun <= 1'b1;
            end else if (cs_fall || soft_rst) begin
                overrun <= 1'b0;
            end
        end
    end

    sfpc_fifo #(.W($bits(sfpc_pkg::sfpc_rx_t)), .D(`SFPC_FIFO_DEPTH)) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (pend_v_q),
        .in_ready  (fifo_rdy),
        .in_data   (pend_q),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_word)
    );

    // ================================================================
    // transmit shifter and pin status
    wire selected = !cs_n_s && shifting;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            so_out    <= 1'b0;
            tx_q      <= '0;
            so_oe     <= 1'b0;
            busy      <= 1'b0;
            standby   <= 1'b1;
            sect_prot <= 1'b0;
            spr_lock  <= 1'b0;
            page_size <= BIN_PAGE ? `SFPC_PAGE_BIN : `SFPC_PAGE_STD;
        end else begin
            // R6: next bit presented on falling sck
            if (selected && rd_active && sck_fall) begin
                if (bit_q == '0) begin
                    {so_out, tx_q} <= tx_byte;
                end else begin
                    so_out <= tx_q[6];
                    tx_q   <= {tx_q[5:0], 1'b0};
                end
            end
            // R1: released whenever deselected
            // R20: driven only during the read phase
            so_oe     <= selected && rd_active && !cs_rise && !soft_rst;
            busy      <= (st_d == sfpc_pkg::ST_BUSY);
            standby   <= cs_n_s && (st_d != sfpc_pkg::ST_BUSY);
            // R8: hardware protection of flagged sectors
            sect_prot <= wp_low && sect_flag;
            spr_lock  <= wp_low;
            // R17: binary size only when strapped
            page_size <= BIN_PAGE ? `SFPC_PAGE_BIN : `SFPC_PAGE_STD;
        end
    end

    // ================================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence busy_hold_s;
        busy [*8];
    endsequence

    // R1: output released after deselect
    so_release_a: assert property (cs_rise |=> !so_oe) // R1
        else $error("serial output still driven after deselect");
    // R2: no bits counted while idle
    desel_ign_a: assert property ((st_q == sfpc_pkg::ST_IDLE) && !cs_fall && !soft_rst // R2
        |=> bit_q == $past(bit_q))
        else $error("bit counter moved while deselected");
    // R4: standby waits for busy to end
    busy_standby_a: assert property (busy |-> !standby) // R4
        else $error("standby during timed cycle");
    // R16: timed cycle holds busy for at least 8 cycles
    busy_len_a: assert property ($rose(busy) && PROG_CYC >= 8 |-> busy_hold_s) // R16
        else $error("timed cycle ended early");
    // R10: discarded command pushes nothing
    drop_quiet_a: assert property ((st_q == sfpc_pkg::ST_DROP) |=> !$rose(pend_v_q)) // R10
        else $error("byte captured from discarded command");
    // R13: reset pin forces idle
    pin_reset_a: assert property (soft_rst |=> st_q == sfpc_pkg::ST_IDLE) // R13
        else $error("reset pin did not force idle");
    // R9: protection register frozen
    spr_freeze_a: assert property (wp_low |=> spr_lock) // R9
        else $error("protection register not frozen");
    // R8: sector protection under wp
    sect_guard_a: assert property (wp_low && sect_flag |=> sect_prot) // R8
        else $error("flagged sector not protected");
    // R18: opcode byte marked first
    opc_first_a: assert property (opc_done && !drop_op |=> pend_v_q && pend_q.first) // R18
        else $error("opcode not marked as first byte");
    // R19: last received bit is the lsb
    msb_order_a: assert property (push_byte |=> pend_q.data[0] == $past(si_s)) // R19
        else $error("bit order wrong");
endmodule
`default_nettype wire

// ---- verif/sfpc_host_model.sv ----
`default_nettype none
// ====================================================================
// host side spi master, slow sck of 2*HALF system clocks
module sfpc_host_model (
    input  wire logic sys_clk,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so_out,
    input  wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 5;
    logic cpol;
    logic so_last;
    logic in_frame;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        cpol = 1'b0;
        so_last = 1'b0;
        in_frame = 1'b0;
    end
    // si toggles outside frames, so a stale level cannot pass for data
    always @(posedge sys_clk) begin
        if (!in_frame) begin
            si <= ~si;
        end
    end
    task automatic open_frame(input logic mode3);
        cpol = mode3;
        @(posedge sys_clk) sck <= mode3;
        in_frame <= 1'b1;
        repeat (HALF) @(posedge sys_clk);
        cs_n <= 1'b0;
        repeat (HALF) @(posedge sys_clk);
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge sys_clk) sck <= 1'b0;
            si <= tx[i];
            repeat (HALF) @(posedge sys_clk);
            sck <= 1'b1;
            rx[i] = so_oe ? so_out : ~so_last;
            so_last = rx[i];
            repeat (HALF - 1) @(posedge sys_clk);
        end
    endtask
    task automatic close_frame();
        @(posedge sys_clk) sck <= cpol;
        repeat (HALF) @(posedge sys_clk);
        cs_n <= 1'b1;
        in_frame <= 1'b0;
        repeat (HALF) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ---- verif/test_serial_flash_pin_control.sv ----
`default_nettype none
module test_serial_flash_pin_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PROG = 200;
    logic               sys_clk;
    logic               rst;
    logic               cs_n;
    logic               sck;
    logic               si;
    logic               wp_n;
    logic               reset_n;
    logic               so_out;
    logic               so_oe;
    logic               rx_valid;
    logic               rx_ready;
    sfpc_pkg::sfpc_rx_t rx_word;
    sfpc_pkg::sfpc_rx_t w;
    logic [7:0]         tx_byte;
    logic               rd_active;
    logic               sect_flag;
    logic               sect_prot;
    logic               spr_lock;
    logic               busy;
    logic               standby;
    logic [8:0]         page_size;
    logic               overrun;
    logic [7:0]         rd;
    logic [8:0]         page_bin;
    int                 n_errors;
    int                 check_count;
    int                 cycles;
    int                 n;

    sfpc_top #(.PROG_CYC(PROG)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si),
        .wp_n_pin(wp_n), .reset_n_pin(reset_n), .so_out(so_out), .so_oe(so_oe),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word), .tx_byte(tx_byte),
        .rd_active(rd_active), .sect_flag(sect_flag), .sect_prot(sect_prot),
        .spr_lock(spr_lock), .busy(busy), .standby(standby), .page_size(page_size),
        .overrun(overrun)
    );
    sfpc_host_model i_host (
        .sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe)
    );
    // binary page strap, only its page size is watched
    sfpc_top #(.PROG_CYC(PROG), .BIN_PAGE(1'b1)) i_dut_bin (
        .sys_clk(sys_clk), .rst(rst), .cs_n_pin(1'b1), .sck_pin(1'b0), .si_pin(1'b0),
        .wp_n_pin(1'b1), .reset_n_pin(1'b1), .so_out(), .so_oe(),
        .rx_valid(), .rx_ready(1'b0), .rx_word(), .tx_byte(8'h00),
        .rd_active(1'b0), .sect_flag(1'b0), .sect_prot(),
        .spr_lock(), .busy(), .standby(), .page_size(page_bin),
        .overrun()
    );

    always #50 sys_clk = ~sys_clk;
    // ====================================================================
    // shared tasks
    task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_clk(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic send(input logic m3, input logic [7:0] q[$]);
        i_host.open_frame(m3);
        foreach (q[i]) i_host.xfer(q[i], rd);
        i_host.close_frame();
    endtask
    task automatic pop(output sfpc_pkg::sfpc_rx_t v);
        int k;
        k = 0;
        @(negedge sys_clk);
        while (rx_valid !== 1'b1 && k < 50) begin
            @(negedge sys_clk);
            k++;
        end
        v = rx_word;
        @(posedge sys_clk) rx_ready <= 1'b1;
        @(posedge sys_clk) rx_ready <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic drain();
        n = 0;
        @(negedge sys_clk);
        while (rx_valid === 1'b1 && n < 8) begin
            pop(w);
            n++;
        end
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(negedge sys_clk);
    endtask
    // ====================================================================
    // scenarios
    task automatic t_rx();
        for (int m = 0; m < 2; m++) begin
            send(m[0], {8'h0b, 8'h1c});
            pop(w);
            chk("opcode word", w, 9'h10b);
            pop(w);
            chk("address word", w, 9'h01c);
            wait_clk(40);
            chk("idle rx_valid", 9'(rx_valid), 9'h000);
        end
        $display("test rx done");
    endtask
    task automatic t_read();
        @(posedge sys_clk) tx_byte <= 8'hc6;
        i_host.open_frame(1'b0);
        i_host.xfer(8'h0b, rd);
        chk("so_oe opcode", 9'(so_oe), 9'h000);
        @(posedge sys_clk) rd_active <= 1'b1;
        repeat (5) @(posedge sys_clk);
        i_host.xfer(8'h00, rd);
        chk("so_oe read", 9'(so_oe), 9'h001);
        chk("read byte", 9'(rd), 9'h0c6);
        i_host.close_frame();
        rd_active <= 1'b0;
        wait_clk(2);
        chk("so_oe after", 9'(so_oe), 9'h000);
        drain();
        $display("test read done");
    endtask
    task automatic t_prog();
        send(1'b0, {8'h01, 8'h00});
        chk("busy", 9'(busy), 9'h001);
        chk("standby busy", 9'(standby), 9'h000);
        n = 0;
        fork
            while (busy === 1'b1 && n < 1000) begin
                @(negedge sys_clk);
                n++;
            end
            send(1'b0, {8'h0b});
        join
        chk("busy length", 9'(n > PROG - 9 && n <= PROG), 9'h001);
        chk("standby done", 9'(standby), 9'h001);
        pop(w);
        chk("prog opcode", w, 9'h101);
        pop(w);
        chk("prog address", w, 9'h000);
        chk("frame in busy", 9'(rx_valid), 9'h000);
        $display("test prog done");
    endtask
    task automatic t_rstpin();
        send(1'b0, {8'h02, 8'h00});
        pop(w);
        chk("erase opcode", w, 9'h102);
        pop(w);
        chk("erase address", w, 9'h000);
        wait_clk(20);
        @(posedge sys_clk) reset_n <= 1'b0;
        wait_clk(6);
        chk("busy aborted", 9'(busy), 9'h000);
        chk("standby reset", 9'(standby), 9'h001);
        send(1'b0, {8'h0b});
        chk("held in reset", 9'(rx_valid), 9'h000);
        @(posedge sys_clk) reset_n <= 1'b1;
        wait_clk(6);
        send(1'b0, {8'h0b});
        pop(w);
        chk("resumed", w, 9'h10b);
        $display("test reset pin done");
    endtask
    task automatic t_wp();
        @(posedge sys_clk) wp_n <= 1'b0;
        sect_flag <= 1'b1;
        wait_clk(6);
        chk("spr_lock", 9'(spr_lock), 9'h001);
        chk("sect_prot", 9'(sect_prot), 9'h001);
        for (int op = 1; op <= 6; op++) begin
            send(1'b0, {8'(op), 8'h00});
            wait_clk(8);
            chk("discarded", 9'({rx_valid, busy}), 9'h000);
        end
        for (int op = 7; op <= 8; op++) begin
            send(1'b0, {8'(op), 8'h00});
            pop(w);
            chk("exempt op", w, 9'(op) | 9'h100);
            drain();
            wait_idle();
        end
        @(posedge sys_clk) wp_n <= 1'b1;
        wait_clk(6);
        chk("unprotected", 9'({sect_prot, spr_lock}), 9'h000);
        @(posedge sys_clk) sect_flag <= 1'b0;
        $display("test wp done");
    endtask
    task automatic t_full();
        send(1'b1, {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
        chk("overrun", 9'(overrun), 9'h001);
        pop(w);
        chk("oldest", w, 9'h111);
        drain();
        chk("fifo count", 9'(n), 9'h004);
        send(1'b0, {8'h0b});
        chk("overrun cleared", 9'(overrun), 9'h000);
        drain();
        chk("empty", 9'(rx_valid), 9'h000);
        $display("test full done");
    endtask
    // ====================================================================
    // closing report
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        wp_n = 1'b1;
        reset_n = 1'b1;
        rx_ready = 1'b0;
        tx_byte = 8'h00;
        rd_active = 1'b0;
        sect_flag = 1'b0;
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        wait_clk(6);
        chk("so_oe rst", 9'(so_oe), 9'h000);
        chk("standby rst", 9'({standby, busy, overrun, rx_valid}), 9'h008);
        chk("page size", page_size, 9'h108);
        @(posedge sys_clk) rst <= 1'b0;
        wait_clk(6);
        chk("page size bin", page_bin, 9'h100);
        t_rx();
        t_read();
        t_prog();
        t_rstpin();
        t_wp();
        t_full();
        results();
    end
endmodule
`default_nettype wire
